// [include/acr_pkg.sv]
// shared constants and types of the front-end control register bank and its host
package acr_pkg;

	// control word layout on the serial link
	localparam int WORD_W = 16;
	localparam int W_CTRL = 15;
	localparam int W_READ = 14;
	localparam int W_DEV_LSB = 11;
	localparam int W_REG_LSB = 8;

	// register indices inside the bank (register address field of the word)
	localparam logic [2:0] REG_MODE = 3'h0;
	localparam logic [2:0] REG_CLOCK = 3'h1;
	localparam logic [2:0] REG_REF = 3'h2;
	localparam logic [2:0] REG_PAIR12 = 3'h3;
	localparam logic [2:0] REG_PAIR34 = 3'h4;
	localparam logic [2:0] REG_PAIR56 = 3'h5;
	localparam logic [2:0] REG_INCFG = 3'h6;
	localparam logic [2:0] REG_INVERT = 3'h7;
	localparam logic [7:0] REG_RESET_VAL = 8'h00;

	// mode_and_cascade fields
	localparam int MODE_RUN = 0;
	localparam int MODE_MIXED = 1;
	localparam int MODE_RSVD = 2;
	localparam int MODE_LOOP = 3;
	localparam int MODE_CASC_LSB = 4;
	localparam int MODE_RESET = 7;
	// clock_dividers fields
	localparam int CLK_DEC_LSB = 0;
	localparam int CLK_SCLK_LSB = 2;
	localparam int CLK_MDIV_LSB = 4;
	localparam int CLK_ECHO = 7;
	// reference_power fields
	localparam int REF_ALL = 0;
	localparam int REF_RSVD_LSB = 1;
	localparam int REF_PWR = 5;
	localparam int REF_PIN = 6;
	localparam int REF_HI = 7;
	// channel pair fields
	localparam int PAIR_GAIN_LO_LSB = 0;
	localparam int PAIR_PWR_LO = 3;
	localparam int PAIR_GAIN_HI_LSB = 4;
	localparam int PAIR_PWR_HI = 7;
	// input_configuration and inversion_and_test fields
	localparam int SEL_CLEAR = 6;
	localparam int SEL_SINGLE = 7;
	localparam int INV_TEST = 6;
	localparam int INV_FLIP = 7;

	// software reset length in divided master clock periods
	localparam logic [2:0] SRST_DM_CYCLES = 3'h4;

	// host register map (byte addresses)
	localparam logic [7:0] HOST_CMD_OFS = 8'h00;
	localparam logic [7:0] HOST_STAT_OFS = 8'h04;
	localparam logic [7:0] HOST_RX_OFS = 8'h08;
	localparam logic [7:0] HOST_CTRL_OFS = 8'h0c;
	localparam int STAT_BUSY = 0;
	localparam int STAT_REPLY = 1;
	localparam int CTRL_DIAG = 0;
	localparam int CTRL_PARTIAL = 1;
	localparam int CTRL_CASC_LSB = 4;
	localparam logic [7:0] CTRL_RESET_VAL = 8'h00;

	// operating mode, one-hot
	typedef enum logic [2:0] {
		OP_PROGRAM = 3'b001,
		OP_DATA = 3'b010,
		OP_MIXED = 3'b100
	} acr_op_t;

	// serial receive and send states, one-hot
	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_SHIFT = 2'b10
	} acr_rx_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} acr_tx_t;

endpackage

// [include/acr_link_if.sv]
// serial link between the control register bank and its host
`timescale 1ns/1ns
interface acr_link_if;
	logic sclk_tick;
	logic host_fs;
	logic host_bit;
	logic dev_fs;
	logic dev_bit;

	modport dev (
		output sclk_tick,
		input host_fs,
		input host_bit,
		output dev_fs,
		output dev_bit
	);

	modport host (
		input sclk_tick,
		output host_fs,
		output host_bit,
		input dev_fs,
		input dev_bit
	);
endinterface

// [rtl/acr_device.sv]
// device end: eight control registers, clock dividers and serial word handling
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ns
module acr_device
	import acr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	acr_link_if.dev link,
	output logic [2:0] run_mode,
	output logic sample_strobe,
	output logic soft_reset_busy,
	output logic [5:0] adc_power,
	output logic [17:0] adc_gain,
	output logic reference_power_on,
	output logic reference_output_pin,
	output logic high_supply_mode,
	output logic [5:0] modulator_clear,
	output logic [5:0] single_ended_on,
	output logic [5:0] polarity_flip,
	output logic test_mode_on,
	output logic port_loopback,
	output logic [2:0] cascade_count
);

	typedef struct packed {
		logic [7:0][7:0] bank;
		logic [2:0] mdiv;
		logic [2:0] sdiv;
		logic [10:0] dcnt;
		logic tick;
		logic sample;
		logic [2:0] srst;
		logic srst_busy;
		acr_rx_t rx;
		logic [3:0] rcnt;
		logic [15:0] rsh;
		acr_tx_t tx;
		logic tpend;
		logic [15:0] tq;
		logic [3:0] tcnt;
		logic [15:0] tsh;
		logic fs_o;
		logic bit_o;
		acr_op_t mode;
		logic [5:0] pwr;
		logic [17:0] gain;
		logic ref_on;
		logic ref_pin;
		logic hi;
		logic [5:0] mclr;
		logic [5:0] se;
		logic [5:0] polarity_flip_enable;
		logic test;
		logic loop;
		logic [2:0] casc;
	} acr_dev_st_t;
	acr_dev_st_t st_reg;
	acr_dev_st_t st_next;

	// master divider code to last count; unused codes fall back to divide by one
	function automatic logic [2:0] mdiv_last(input logic [2:0] code);
		if (code <= 3'h4) begin
			mdiv_last = code;
		end else begin
			mdiv_last = 3'h0;
		end
	endfunction

	// serial divider code to last count: 8,4,2,1 periods
	function automatic logic [2:0] sclk_last(input logic [1:0] code);
		sclk_last = 3'h7 >> code;
	endfunction

	// decimation code to last count: 2048,1024,512,256 periods
	function automatic logic [10:0] dec_last(input logic [1:0] code);
		dec_last = 11'h7ff >> code;
	endfunction

	logic [7:0] mode_r;
	logic [7:0] clk_r;
	logic [15:0] word;
	logic dm;
	logic send;
	logic [15:0] out_word;

	assign mode_r = st_reg.bank[REG_MODE];
	assign clk_r = st_reg.bank[REG_CLOCK];

	always_comb begin
		st_next = st_reg;
		word = {st_reg.rsh[14:0], link.host_bit};
		send = 1'b0;
		out_word = word;

		// clock chain: master divider feeds serial and decimation dividers
		dm = (st_reg.mdiv >= mdiv_last(clk_r[CLK_MDIV_LSB +: 3]));
		st_next.mdiv = dm ? 3'h0 : st_reg.mdiv + 3'h1;
		st_next.tick = 1'b0;
		st_next.sample = 1'b0;
		if (dm) begin
			if (st_reg.sdiv >= sclk_last(clk_r[CLK_SCLK_LSB +: 2])) begin
				st_next.sdiv = 3'h0;
				st_next.tick = 1'b1;
			end else begin
				st_next.sdiv = st_reg.sdiv + 3'h1;
			end
			if (st_reg.dcnt >= dec_last(clk_r[CLK_DEC_LSB +: 2])) begin
				st_next.dcnt = 11'h000;
				st_next.sample = 1'b1;
			end else begin
				st_next.dcnt = st_reg.dcnt + 11'h001;
			end
		end

		// receive: one frame bit marks the first of sixteen bits
		if (st_reg.tick) begin
			case (st_reg.rx)
				RX_IDLE: begin
					if (link.host_fs) begin
						st_next.rsh = word;
						st_next.rcnt = 4'h1;
						st_next.rx = RX_SHIFT;
					end
				end
				RX_SHIFT: begin
					st_next.rsh = word;
					if (st_reg.rcnt == 4'hf) begin
						st_next.rx = RX_IDLE;
						if (word[W_CTRL] && word[W_DEV_LSB +: 3] == 3'h0) begin
							if (!word[W_READ]) begin
								st_next.bank[word[W_REG_LSB +: 3]] = word[7:0];
								if (word[W_REG_LSB +: 3] == REG_MODE && word[MODE_RESET]) begin
									st_next.srst = SRST_DM_CYCLES;
								end
							end else begin
								out_word = {word[15:8], st_reg.bank[word[W_REG_LSB +: 3]]};
								send = 1'b1;
							end
						end else if (word[W_CTRL]) begin
							// not ours: pass on with the address stepped down
							out_word = {word[15:14], word[W_DEV_LSB +: 3] - 3'h1, word[10:0]};
							send = 1'b1;
						end
						if (clk_r[CLK_ECHO] && word[W_CTRL]) begin
							send = 1'b1;
						end
						if (mode_r[MODE_LOOP]) begin
							send = 1'b1;
						end
					end else begin
						st_next.rcnt = st_reg.rcnt + 4'h1;
					end
				end
				default: st_next.rx = RX_IDLE;
			endcase
		end
		// one word of holding; a later word overwrites one not yet started
		if (send) begin
			st_next.tpend = 1'b1;
			st_next.tq = out_word;
		end

		// send: frame bit with the first bit, then fifteen more
		if (st_reg.tick) begin
			st_next.fs_o = 1'b0;
			case (st_reg.tx)
				TX_IDLE: begin
					st_next.bit_o = 1'b0;
					if (st_reg.tpend) begin
						st_next.fs_o = 1'b1;
						st_next.bit_o = st_reg.tq[15];
						st_next.tsh = {st_reg.tq[14:0], 1'b0};
						st_next.tcnt = 4'h1;
						st_next.tpend = send;
						st_next.tx = TX_SEND;
					end
				end
				TX_SEND: begin
					st_next.bit_o = st_reg.tsh[15];
					st_next.tsh = {st_reg.tsh[14:0], 1'b0};
					st_next.tcnt = st_reg.tcnt + 4'h1;
					if (st_reg.tcnt == 4'hf) begin
						st_next.tx = TX_IDLE;
					end
				end
				default: st_next.tx = TX_IDLE;
			endcase
		end

		// software reset clears the bank and the link for four periods
		if (st_reg.srst != 3'h0 || st_next.srst != 3'h0) begin
			st_next.bank = {8{REG_RESET_VAL}};
			st_next.rx = RX_IDLE;
			st_next.tx = TX_IDLE;
			st_next.tpend = 1'b0;
			st_next.fs_o = 1'b0;
			st_next.bit_o = 1'b0;
			if (st_reg.srst != 3'h0 && dm) begin
				st_next.srst = st_reg.srst - 3'h1;
			end
		end
		st_next.srst_busy = (st_next.srst != 3'h0);
		// decoded outputs follow the bank in the same edge
		if (st_next.bank[REG_MODE][MODE_MIXED]) begin
			st_next.mode = OP_MIXED;
		end else if (st_next.bank[REG_MODE][MODE_RUN]) begin
			st_next.mode = OP_DATA;
		end else begin
			st_next.mode = OP_PROGRAM;
		end
		st_next.loop = st_next.bank[REG_MODE][MODE_LOOP];
		st_next.casc = st_next.bank[REG_MODE][MODE_CASC_LSB +: 3];
		for (int p = 0; p < 3; p++) begin
			st_next.gain[6*p +: 3] = st_next.bank[REG_PAIR12 + 3'(p)][PAIR_GAIN_LO_LSB +: 3];
			st_next.gain[6*p+3 +: 3] = st_next.bank[REG_PAIR12 + 3'(p)][PAIR_GAIN_HI_LSB +: 3];
			st_next.pwr[2*p] = st_next.bank[REG_PAIR12 + 3'(p)][PAIR_PWR_LO];
			st_next.pwr[2*p+1] = st_next.bank[REG_PAIR12 + 3'(p)][PAIR_PWR_HI];
		end
		if (st_next.bank[REG_REF][REF_ALL]) begin
			st_next.pwr = 6'h3f;
		end
		// a running channel needs the reference whatever its own bit says
		st_next.ref_on = st_next.bank[REG_REF][REF_PWR] | (|st_next.pwr);
		st_next.ref_pin = st_next.bank[REG_REF][REF_PIN];
		st_next.hi = st_next.bank[REG_REF][REF_HI];
		st_next.mclr = st_next.bank[REG_INCFG][5:0] & {6{st_next.bank[REG_INCFG][SEL_CLEAR]}};
		st_next.se = st_next.bank[REG_INCFG][5:0] & {6{st_next.bank[REG_INCFG][SEL_SINGLE]}};
		st_next.polarity_flip_enable = st_next.bank[REG_INVERT][5:0] & {6{st_next.bank[REG_INVERT][INV_FLIP]}};
		st_next.test = st_next.bank[REG_INVERT][INV_TEST];
	end

	// single state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.rx <= RX_IDLE;
			st_reg.tx <= TX_IDLE;
			st_reg.mode <= OP_PROGRAM;
		end else begin
			st_reg <= st_next;
		end
	end

	assign link.sclk_tick = st_reg.tick;
	assign link.dev_fs = st_reg.fs_o;
	assign link.dev_bit = st_reg.bit_o;
	assign run_mode = st_reg.mode;
	assign sample_strobe = st_reg.sample;
	assign soft_reset_busy = st_reg.srst_busy;
	assign adc_power = st_reg.pwr;
	assign adc_gain = st_reg.gain;
	assign reference_power_on = st_reg.ref_on;
	assign reference_output_pin = st_reg.ref_pin;
	assign high_supply_mode = st_reg.hi;
	assign modulator_clear = st_reg.mclr;
	assign single_ended_on = st_reg.se;
	assign polarity_flip = st_reg.polarity_flip_enable;
	assign test_mode_on = st_reg.test;
	assign port_loopback = st_reg.loop;
	assign cascade_count = st_reg.casc;

endmodule

// [rtl/acr_host.sv]
// host end: APB command registers driving control words onto the serial link
`timescale 1ns/1ns
module acr_host
	import acr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	acr_link_if.host link
);

	typedef struct packed {
		logic [7:0] ctrl;
		logic [15:0] cmd;
		logic busy;
		logic [15:0] rxw;
		logic reply;
		acr_tx_t tx;
		logic [3:0] tcnt;
		logic [15:0] tsh;
		logic fs_o;
		logic bit_o;
		acr_rx_t rx;
		logic [3:0] rcnt;
		logic [15:0] rsh;
		logic [31:0] rdata;
		logic rdy;
		logic err;
	} acr_host_st_t;

	acr_host_st_t st_reg;
	acr_host_st_t st_next;

	// reshape a register write so that reserved and diagnostic bits stay safe
	function automatic logic [15:0] shape(input logic [15:0] w, input logic [7:0] c);
		shape = w;
		if (w[W_CTRL] && !w[W_READ]) begin
			if (w[W_REG_LSB +: 3] == REG_MODE) begin
				shape[MODE_RSVD] = 1'b0;
				shape[MODE_LOOP] = w[MODE_LOOP] & c[CTRL_DIAG];
				shape[MODE_CASC_LSB +: 3] = c[CTRL_CASC_LSB +: 3];
			end else if (w[W_REG_LSB +: 3] == REG_CLOCK) begin
				shape[CLK_ECHO] = w[CLK_ECHO] & c[CTRL_DIAG];
			end else if (w[W_REG_LSB +: 3] == REG_REF) begin
				shape[REF_RSVD_LSB +: 4] = 4'h0;
				shape[REF_ALL] = w[REF_ALL] & ~c[CTRL_PARTIAL];
			end
		end
	endfunction

	logic setup;
	logic access;
	logic [15:0] word;

	assign setup = psel && !penable;
	assign access = psel && penable && st_reg.rdy;

	always_comb begin
		st_next = st_reg;
		word = {st_reg.rsh[14:0], link.dev_bit};

		// answer prepared in the setup cycle, so access never waits
		st_next.rdy = setup;
		st_next.err = 1'b0; // error stands only with ready
		if (setup) begin
			st_next.rdata = 32'h0000_0000;
			if (paddr == HOST_CMD_OFS) begin
				st_next.rdata = {16'h0000, st_reg.cmd};
				st_next.err = pwrite && st_reg.busy;
			end else if (paddr == HOST_STAT_OFS) begin
				st_next.rdata = {30'h0, st_reg.reply, st_reg.busy};
			end else if (paddr == HOST_RX_OFS) begin
				st_next.rdata = {16'h0000, st_reg.rxw};
			end else if (paddr == HOST_CTRL_OFS) begin
				st_next.rdata = {24'h000000, st_reg.ctrl};
			end else begin
				st_next.err = 1'b1;
			end
		end
		if (access && pwrite && !st_reg.err) begin
			if (paddr == HOST_CMD_OFS) begin
				st_next.cmd = shape(pwdata[15:0], st_reg.ctrl);
				st_next.busy = 1'b1;
			end else if (paddr == HOST_STAT_OFS && pwdata[STAT_REPLY]) begin
				st_next.reply = 1'b0;
			end else if (paddr == HOST_CTRL_OFS) begin
				st_next.ctrl = pwdata[7:0];
			end
		end

		// send the pending word on the device's bit ticks
		if (link.sclk_tick) begin
			st_next.fs_o = 1'b0;
			case (st_reg.tx)
				TX_IDLE: begin
					st_next.bit_o = 1'b0;
					if (st_reg.busy) begin
						st_next.fs_o = 1'b1;
						st_next.bit_o = st_reg.cmd[15];
						st_next.tsh = {st_reg.cmd[14:0], 1'b0};
						st_next.tcnt = 4'h1;
						st_next.tx = TX_SEND;
					end
				end
				TX_SEND: begin
					st_next.bit_o = st_reg.tsh[15];
					st_next.tsh = {st_reg.tsh[14:0], 1'b0};
					st_next.tcnt = st_reg.tcnt + 4'h1;
					if (st_reg.tcnt == 4'hf) begin
						st_next.tx = TX_IDLE;
						st_next.busy = 1'b0;
					end
				end
				default: st_next.tx = TX_IDLE;
			endcase

			// collect words coming back; a new word wins over a clear
			case (st_reg.rx)
				RX_IDLE: begin
					if (link.dev_fs) begin
						st_next.rsh = word;
						st_next.rcnt = 4'h1;
						st_next.rx = RX_SHIFT;
					end
				end
				RX_SHIFT: begin
					st_next.rsh = word;
					st_next.rcnt = st_reg.rcnt + 4'h1;
					if (st_reg.rcnt == 4'hf) begin
						st_next.rxw = word;
						st_next.reply = 1'b1;
						st_next.rx = RX_IDLE;
					end
				end
				default: st_next.rx = RX_IDLE;
			endcase
		end
	end

	// single state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.ctrl <= CTRL_RESET_VAL;
			st_reg.tx <= TX_IDLE;
			st_reg.rx <= RX_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.rdata;
	assign pready = st_reg.rdy;
	assign pslverr = st_reg.err;
	assign link.host_fs = st_reg.fs_o;
	assign link.host_bit = st_reg.bit_o;

endmodule

// [tb/acr_assertions.sv]
// concurrent checks on the link, the apb answer and the device outputs
`timescale 1ns/1ns
module acr_assertions
	import acr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sclk_tick,
	input wire logic host_fs,
	input wire logic host_bit,
	input wire logic [2:0] run_mode,
	input wire logic [5:0] adc_power,
	input wire logic reference_power_on,
	input wire logic soft_reset_busy,
	input wire logic [5:0] modulator_clear,
	input wire logic [5:0] single_ended_on,
	input wire logic sample_strobe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// software reset: starts, holds four periods at the default divider, then ends
	sequence srst_start;
		$rose(soft_reset_busy);
	endsequence
	sequence srst_hold;
		soft_reset_busy [*4];
	endsequence

	a_mode_onehot: assert property (run_mode == OP_PROGRAM || run_mode == OP_DATA
		|| run_mode == OP_MIXED) else $error("run mode not a legal code");
	a_ref_follows_channel: assert property (|adc_power |-> reference_power_on)
		else $error("reference off while a channel is powered");
	a_srst_clears_bank: assert property (soft_reset_busy |->
		adc_power == 6'h00 && run_mode == OP_PROGRAM) else $error("bank not cleared in reset");
	a_srst_length: assert property (srst_start |-> srst_hold ##[1:3] !soft_reset_busy)
		else $error("software reset length wrong");
	a_select_masks_both: assert property (|(modulator_clear & single_ended_on) |->
		modulator_clear == single_ended_on) else $error("selects differ between modes");
	a_strobe_single: assert property (sample_strobe |=> !sample_strobe)
		else $error("sample strobe longer than one cycle");
	a_apb_zero_wait: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held past access cycle");
	a_error_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_host_on_tick: assert property ($changed({host_fs, host_bit}) |-> $past(sclk_tick))
		else $error("host link changed off a tick");
endmodule

// [tb/tb_afe_control_register_bank.sv]
// bench: apb host end drives the device end over the link, device outputs checked
`timescale 1ns/1ns
module tb_afe_control_register_bank
	import acr_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic e;
	logic [2:0] run_mode, cascade_count;
	logic sample_strobe, soft_reset_busy, reference_power_on, reference_output_pin;
	logic high_supply_mode, test_mode_on, port_loopback;
	logic [5:0] adc_power, modulator_clear, single_ended_on, polarity_flip;
	logic [17:0] adc_gain;
	logic srst_single_ended_on = 1'b0;
	int miscompares, tests_run, n;
	logic [7:0] mv [4] = '{8'h01, 8'h03, 8'h02, 8'h08};
	logic [2:0] mx [4] = '{OP_DATA, OP_MIXED, OP_MIXED, OP_PROGRAM};
	logic [7:0] rv [4] = '{8'h01, 8'h20, 8'h40, 8'h9e};
	logic [8:0] rx [4] = '{9'h1fc, 9'h004, 9'h002, 9'h001};
	logic [7:0] cv [4] = '{8'h0f, 8'h1b, 8'h44, 8'h50};
	int sp [4] = '{256, 512, 10240, 2048};
	int tp [4] = '{1, 4, 20, 8};

	acr_link_if link();
	acr_device u_acr_device (.pclk(pclk), .presetn(presetn), .link(link), .run_mode(run_mode),
		.sample_strobe(sample_strobe), .soft_reset_busy(soft_reset_busy),
		.adc_power(adc_power), .adc_gain(adc_gain), .reference_power_on(reference_power_on),
		.reference_output_pin(reference_output_pin), .high_supply_mode(high_supply_mode),
		.modulator_clear(modulator_clear), .single_ended_on(single_ended_on),
		.polarity_flip(polarity_flip), .test_mode_on(test_mode_on),
		.port_loopback(port_loopback), .cascade_count(cascade_count));
	acr_host u_acr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	acr_assertions u_acr_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pready(pready), .pslverr(pslverr), .sclk_tick(link.sclk_tick),
		.host_fs(link.host_fs), .host_bit(link.host_bit), .run_mode(run_mode),
		.adc_power(adc_power), .reference_power_on(reference_power_on),
		.soft_reset_busy(soft_reset_busy), .modulator_clear(modulator_clear),
		.single_ended_on(single_ended_on), .sample_strobe(sample_strobe));

	// 50 mhz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// a reset lasts only a few cycles, so remember that soft_reset_busy was seen
	always @(posedge pclk) begin
		if (soft_reset_busy === 1'b1) srst_single_ended_on <= 1'b1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; ready, read data and error are taken at the completing edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) miscompares++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic poll(input int b, input logic v);
		int k;
		k = 0;
		do begin
			apb(1'b0, HOST_STAT_OFS, 32'h0, d, e);
			k++;
		end while (d[b] !== v && k < 3000);
		if (k >= 3000) miscompares++;
	endtask

	// send a word, then let two bit times pass so the device has acted on it
	task automatic send(input logic [15:0] w);
		apb(1'b1, HOST_CMD_OFS, {16'h0, w}, d, e);
		poll(STAT_BUSY, 1'b0);
		repeat (2) @(posedge pclk iff link.sclk_tick === 1'b1);
	endtask

	task automatic wreg(input logic [2:0] r, input logic [7:0] v);
		send({1'b1, 1'b0, 3'h0, r, v});
	endtask

	// cycles between two pulses of the strobe (0) or the bit tick (1)
	task automatic period(input logic which, output int cnt);
		do @(negedge pclk);
		while ((which ? link.sclk_tick : sample_strobe) !== 1'b1);
		cnt = 0;
		do begin
			@(negedge pclk);
			cnt++;
		end while ((which ? link.sclk_tick : sample_strobe) !== 1'b1 && cnt < 20000);
	endtask

	task automatic summarize;
		if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// watchdog well past the longest expected run
	initial begin
		#2000000;
		miscompares++;
		summarize();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(run_mode, OP_PROGRAM);
		chk(adc_power, 6'h00);
		// diag allowed, cascade of three; unmapped address refused
		apb(1'b1, HOST_CTRL_OFS, 32'h31, d, e);
		apb(1'b0, HOST_CTRL_OFS, 32'h0, d, e);
		chk(d, 32'h31);
		apb(1'b0, 8'h10, 32'h0, d, e);
		chk(d, 32'h0);
		chk(e, 1'b1);
		for (int i = 0; i < 4; i++) begin
			wreg(REG_MODE, mv[i]);
			chk(run_mode, mx[i]);
			chk(port_loopback, i == 3);
			chk(cascade_count, 3'h3);
		end
		// a second command while busy is refused and has no effect
		apb(1'b1, HOST_CMD_OFS, 32'h8000, d, e);
		apb(1'b1, HOST_CMD_OFS, 32'h8201, d, e);
		chk(e, 1'b1);
		poll(STAT_BUSY, 1'b0);
		chk(adc_power, 6'h00);
		for (int i = 0; i < 4; i++) begin
			wreg(REG_REF, rv[i]);
			chk({adc_power, reference_power_on, reference_output_pin, high_supply_mode},
				rx[i]);
		end
		wreg(REG_PAIR12, 8'ha5);
		wreg(REG_PAIR34, 8'h8e);
		wreg(REG_PAIR56, 8'h37);
		chk(adc_power, 6'h0e);
		chk(adc_gain, 18'h1f195);
		chk(reference_power_on, 1'b1);
		// read a register back over the link
		apb(1'b1, HOST_STAT_OFS, 32'h2, d, e);
		send({1'b1, 1'b1, 3'h0, REG_PAIR12, 8'h00});
		poll(STAT_REPLY, 1'b1);
		apb(1'b0, HOST_RX_OFS, 32'h0, d, e);
		chk(d, 32'hc3a5);
		// echo on: the next control word comes back unchanged
		wreg(REG_CLOCK, 8'h80);
		apb(1'b1, HOST_STAT_OFS, 32'h2, d, e);
		wreg(REG_PAIR56, 8'h37);
		poll(STAT_REPLY, 1'b1);
		apb(1'b0, HOST_RX_OFS, 32'h0, d, e);
		chk(d, 32'h8537);
		wreg(REG_INCFG, 8'h55);
		chk({modulator_clear, single_ended_on}, 12'h540);
		wreg(REG_INCFG, 8'hea);
		chk({modulator_clear, single_ended_on}, 12'haaa);
		wreg(REG_INVERT, 8'hc3);
		chk({polarity_flip, test_mode_on}, 7'h07);
		wreg(REG_INVERT, 8'h23);
		chk({polarity_flip, test_mode_on}, 7'h00);
		// second period measured, the first may straddle the divider change
		for (int i = 0; i < 4; i++) begin
			wreg(REG_CLOCK, cv[i]);
			period(1'b0, n);
			period(1'b0, n);
			chk(n, sp[i]);
			period(1'b1, n);
			period(1'b1, n);
			chk(n, tp[i]);
		end
		// partial channels: the host drops the global power bit
		apb(1'b1, HOST_CTRL_OFS, 32'h33, d, e);
		wreg(REG_REF, 8'h01);
		chk(adc_power, 6'h0e);
		apb(1'b1, HOST_CTRL_OFS, 32'h31, d, e);
		wreg(REG_REF, 8'h01);
		wreg(REG_MODE, 8'h81);
		chk(srst_single_ended_on, 1'b1);
		chk({run_mode, adc_power}, {OP_PROGRAM, 6'h00});
		summarize();
	end
endmodule
